// File: i2csd_pkg.sv
// Functional notes
// - The slave answers as receiver or transmitter to the 7-bit address held in bits 7:1 of its own address register.
// - Two hold-time detection registers exist, one for the display channel slave and one for the multi-master slave, both reset to zero.
// - With bit 7 of a hold-time register clear, detection needs exactly one sample and bits 6:0 are ignored.
// - Hold-time samples are taken at half the system clock rate.
// - The display channel joins a two-wire slave with a 256-byte buffer that the processor fills before a host reads it.
// - The display channel only ever acts as a slave and never starts a transfer.
// - Both the DDC1 and the DDC2b protocols are served without per-byte processor work.
// - A software mode lets the processor supply each transmitted byte on request.
// - The link uses vertical sync, serial data and serial clock pins.
// - Bytes move most significant bit first.
// - The buffer pointer steps by one after every buffer access by software or by the link.
package i2csd_pkg;

    // ****************************************************************
    // Register indices; the byte address is four times the index.
    // ****************************************************************
    localparam logic [7:0] IDX_HOLD_DDC = 8'hD1;
    localparam logic [7:0] IDX_HOLD_MM  = 8'hD2;
    localparam logic [7:0] IDX_DAT      = 8'hD0;
    localparam logic [7:0] IDX_OWN      = 8'hCF;
    localparam logic [7:0] IDX_BUF      = 8'hD4;
    localparam logic [7:0] IDX_TXD      = 8'hD5;
    localparam logic [7:0] IDX_PTR      = 8'hD6;
    localparam logic [7:0] IDX_CTRL     = 8'hD7;
    localparam logic [7:0] IDX_STAT     = 8'hD8;
    localparam logic [7:0] IDX_MASK     = 8'hD9;

    // ****************************************************************
    // Reset values and field positions.
    // ****************************************************************
    localparam logic [7:0] HOLD_RST     = 8'h00;
    localparam logic [7:0] OWN_RST      = 8'hA0;
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam int unsigned CTRL_EN     = 0;
    localparam int unsigned CTRL_DDC1   = 1;
    localparam int unsigned CTRL_SW     = 2;
    localparam int unsigned CTRL_MODE2  = 7;
    localparam int unsigned EV_W        = 5;
    localparam int unsigned EV_ADDR     = 0;
    localparam int unsigned EV_RX       = 1;
    localparam int unsigned EV_TXREQ    = 2;
    localparam int unsigned EV_STOP     = 3;
    localparam int unsigned EV_SWITCH   = 4;
    localparam logic [3:0] BIT_LAST     = 4'h8;
    localparam logic [3:0] DDC1_NULL    = 4'h8;
    localparam int unsigned SAMPLE_DIV  = 2;
    localparam logic [2:0] HSIZE_WORD   = 3'h2;

    typedef enum logic [2:0] {
        I2CSD_IDLE, I2CSD_ADDR, I2CSD_AACK, I2CSD_RX, I2CSD_RACK, I2CSD_TX, I2CSD_TACK
    } i2csd_state_t;

    function automatic logic [7:0] hold_samples(input logic [7:0] v);
        return v[7] ? ({1'b0, v[6:0]} + 8'h01) : 8'h01;
    endfunction

endpackage

// File: i2csd_mem_if.sv
`timescale 1ns/1ns
interface i2csd_mem_if #(parameter int unsigned AW = 8);
    logic          we;
    logic [AW-1:0] wa;
    logic [7:0]    wd;
    logic          re;
    logic [AW-1:0] ra;
    logic [7:0]    rd;
    modport mem  (input we, wa, wd, re, ra, output rd);
    modport user (output we, wa, wd, re, ra, input rd);
endinterface

// File: i2csd_buf.sv
`timescale 1ns/1ns
module i2csd_buf #(
    parameter int unsigned AW = 8
) (
    input wire logic hclk,
    i2csd_mem_if.mem m
);
    logic [7:0] mem_q [0:(1<<AW)-1];
    logic [7:0] rd_q;

    always_ff @(posedge hclk) begin
        if (m.we) begin
            mem_q[m.wa] <= m.wd;
        end
    end

    always_ff @(posedge hclk) begin
        if (m.re) begin
            rd_q <= mem_q[m.ra];
        end
    end

    assign m.rd = rd_q;
endmodule // i2csd_buf

// File: i2csd_top.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
module i2csd_top
    import i2csd_pkg::*;
#(
    parameter int unsigned AW = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        vsync_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    logic [2:0]      vs_sync_q, scl_sync_q, sda_sync_q;
    logic            vs_rise, scl_rise, scl_fall, scl_s, sda_s;
    logic            tick_q, ref_q, start_q, stop_q;
    logic [7:0]      cnt_q, need;
    logic [7:0]      hold_ddc_q, hold_mm_q, own_q, ctrl_q, txd_q, dat_q;
    logic [EV_W-1:0] st_q, mask_q, ev_q;
    logic [AW-1:0]   ptr_q;
    logic            wr_q, rd_q, buf_rd_q, acc, ahb_buf_rd;
    logic [7:0]      idx_q;
    i2csd_state_t    state_q;
    logic [3:0]      bit_q, d1cnt_q;
    logic [7:0]      rx_q, tx_q;
    logic            rw_q, ack_q, first_q, mode2_q, d1low_q, ptr_set_q;
    logic            txv_q, fetch_q, fack_q, fetch_go;
    logic            en, sw, d1_act, i2c_act, load_next, shift_tx, buf_wr;

    i2csd_mem_if #(.AW(AW)) mif ();

    i2csd_buf #(.AW(AW)) u_buf (
        .hclk (hclk),
        .m    (mif.mem)
    );

    // ****************************************************************
    // Pin synchronisers and edge detection.
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vs_sync_q  <= 3'h0;
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
        end else begin
            vs_sync_q  <= {vs_sync_q[1:0], vsync_i};
            scl_sync_q <= {scl_sync_q[1:0], scl_i};
            sda_sync_q <= {sda_sync_q[1:0], sda_i};
        end
    end

    assign scl_s    = scl_sync_q[1];
    assign sda_s    = sda_sync_q[1];
    assign vs_rise  = vs_sync_q[1] & ~vs_sync_q[2];
    assign scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
    assign scl_fall = ~scl_sync_q[1] & scl_sync_q[2];

    // ****************************************************************
    // Start and stop detection with programmable hold time.
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= ~tick_q;
        end
    end

    assign need = hold_samples(hold_ddc_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_q   <= 1'b1;
            cnt_q   <= 8'h00;
            start_q <= 1'b0;
            stop_q  <= 1'b0;
        end else begin
            start_q <= 1'b0;
            stop_q  <= 1'b0;
            if (sda_s == ref_q) begin
                cnt_q <= 8'h00;
            end else if (!scl_s) begin
                ref_q <= sda_s;
                cnt_q <= 8'h00;
            end else if (tick_q) begin
                if (cnt_q + 8'h01 == need) begin
                    ref_q   <= sda_s;
                    cnt_q   <= 8'h00;
                    start_q <= ~sda_s;
                    stop_q  <= sda_s;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end

    // ****************************************************************
    // Link engine: DDC1 stream and two-wire slave.
    // ****************************************************************
    assign en      = ctrl_q[CTRL_EN];
    assign sw      = ctrl_q[CTRL_SW];
    assign d1_act  = en & ctrl_q[CTRL_DDC1] & ~mode2_q;
    assign i2c_act = en & ~d1_act;

    always_comb begin
        load_next = (i2c_act & scl_fall & (((state_q == I2CSD_AACK) & rw_q)
                    | ((state_q == I2CSD_TACK) & ack_q)))
                    | (d1_act & ~scl_fall & vs_rise & (d1cnt_q == DDC1_NULL));
        shift_tx  = (i2c_act & scl_fall & (state_q == I2CSD_TX))
                    | (d1_act & ~scl_fall & vs_rise & (d1cnt_q != DDC1_NULL));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= I2CSD_IDLE;
            bit_q     <= 4'h0;
            rx_q      <= 8'h00;
            rw_q      <= 1'b0;
            ack_q     <= 1'b0;
            first_q   <= 1'b0;
            mode2_q   <= 1'b0;
            d1cnt_q   <= DDC1_NULL;
            d1low_q   <= 1'b0;
            ev_q      <= '0;
            ptr_set_q <= 1'b0;
            dat_q     <= 8'h00;
        end else begin
            ev_q      <= '0;
            ptr_set_q <= 1'b0;
            if (wr_q && idx_q == IDX_DAT) begin
                dat_q <= hwdata[7:0];
            end
            if (load_next && sw) begin
                ev_q[EV_TXREQ] <= 1'b1;
            end
            if (!en) begin
                state_q <= I2CSD_IDLE;
                mode2_q <= 1'b0;
                d1cnt_q <= DDC1_NULL;
                d1low_q <= 1'b0;
            end else if (d1_act) begin
                if (scl_fall) begin
                    mode2_q           <= 1'b1;
                    ev_q[EV_SWITCH]   <= 1'b1;
                    d1low_q           <= 1'b0;
                end else if (vs_rise) begin
                    if (d1cnt_q == DDC1_NULL) begin
                        d1low_q <= 1'b0;
                        d1cnt_q <= 4'h0;
                    end else begin
                        d1low_q <= ~tx_q[7];
                        d1cnt_q <= d1cnt_q + 4'h1;
                    end
                end
            end else if (start_q) begin
                state_q <= I2CSD_ADDR;
                bit_q   <= 4'h0;
            end else if (stop_q) begin
                if (state_q != I2CSD_IDLE) begin
                    ev_q[EV_STOP] <= 1'b1;
                end
                state_q <= I2CSD_IDLE;
            end else if (scl_rise) begin
                if (state_q == I2CSD_ADDR || state_q == I2CSD_RX) begin
                    rx_q  <= {rx_q[6:0], sda_s};
                    bit_q <= bit_q + 4'h1;
                end else if (state_q == I2CSD_TX) begin
                    bit_q <= bit_q + 4'h1;
                end else if (state_q == I2CSD_TACK) begin
                    ack_q <= ~sda_s;
                end
            end else if (scl_fall) begin
                case (state_q)
                    I2CSD_ADDR: begin
                        if (bit_q == BIT_LAST) begin
                            if (rx_q[7:1] == own_q[7:1]) begin
                                state_q       <= I2CSD_AACK;
                                rw_q          <= rx_q[0];
                                first_q       <= ~rx_q[0];
                                ev_q[EV_ADDR] <= 1'b1;
                            end else begin
                                state_q <= I2CSD_IDLE;
                            end
                        end
                    end
                    I2CSD_AACK: begin
                        state_q <= rw_q ? I2CSD_TX : I2CSD_RX;
                        bit_q   <= 4'h0;
                    end
                    I2CSD_RX: begin
                        if (bit_q == BIT_LAST) begin
                            state_q <= I2CSD_RACK;
                            first_q <= 1'b0;
                            if (first_q) begin
                                ptr_set_q <= 1'b1;
                            end else begin
                                dat_q       <= rx_q;
                                ev_q[EV_RX] <= 1'b1;
                            end
                        end
                    end
                    I2CSD_RACK: begin
                        state_q <= I2CSD_RX;
                        bit_q   <= 4'h0;
                    end
                    I2CSD_TX: begin
                        if (bit_q == BIT_LAST) begin
                            state_q <= I2CSD_TACK;
                        end
                    end
                    I2CSD_TACK: begin
                        state_q <= ack_q ? I2CSD_TX : I2CSD_IDLE;
                        bit_q   <= 4'h0;
                    end
                    default: begin
                        state_q <= I2CSD_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Transmit byte, buffer fetch and pointer.
    // ****************************************************************
    assign fetch_go = fetch_q & ~ahb_buf_rd;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_q    <= 8'hFF;
            txv_q   <= 1'b0;
            fetch_q <= 1'b0;
            fack_q  <= 1'b0;
        end else begin
            fack_q <= fetch_go;
            if (fetch_go) begin
                fetch_q <= 1'b0;
            end
            if (fack_q) begin
                tx_q  <= mif.rd;
                txv_q <= 1'b1;
            end else if (load_next) begin
                if (sw) begin
                    tx_q  <= txd_q;
                    txv_q <= 1'b1;
                end else begin
                    fetch_q <= 1'b1;
                    txv_q   <= 1'b0;
                end
            end else if (shift_tx) begin
                tx_q <= {tx_q[6:0], 1'b1};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_q <= '0;
        end else if (wr_q && idx_q == IDX_PTR) begin
            ptr_q <= hwdata[AW-1:0];
        end else if (ptr_set_q) begin
            ptr_q <= rx_q[AW-1:0];
        end else begin
            ptr_q <= ptr_q + AW'(ahb_buf_rd | fetch_go) + AW'(buf_wr);
        end
    end

    assign buf_wr  = wr_q & (idx_q == IDX_BUF);
    assign mif.we  = buf_wr;
    assign mif.wa  = ptr_q;
    assign mif.wd  = hwdata[7:0];
    assign mif.re  = ahb_buf_rd | fetch_go;
    assign mif.ra  = ptr_q + AW'(buf_wr);

    assign sda_o  = 1'b0;
    assign sda_oe = (i2c_act & ((state_q == I2CSD_AACK) | (state_q == I2CSD_RACK)
                    | ((state_q == I2CSD_TX) & txv_q & ~tx_q[7]))) | (d1_act & d1low_q);

    // ****************************************************************
    // Bus slave and registers.
    // ****************************************************************
    assign acc        = hsel & htrans[1] & hready & (hsize == HSIZE_WORD) & (haddr[31:10] == 22'h0);
    assign ahb_buf_rd = acc & ~hwrite & (haddr[9:2] == IDX_BUF);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            buf_rd_q <= 1'b0;
            idx_q    <= 8'h00;
        end else if (hready) begin
            wr_q     <= acc & hwrite;
            rd_q     <= acc & ~hwrite;
            buf_rd_q <= ahb_buf_rd;
            idx_q    <= haddr[9:2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_ddc_q <= HOLD_RST;
            hold_mm_q  <= HOLD_RST;
            own_q      <= OWN_RST;
            ctrl_q     <= CTRL_RST;
            txd_q      <= 8'h00;
            mask_q     <= '0;
        end else if (wr_q) begin
            case (idx_q)
                IDX_HOLD_DDC: hold_ddc_q <= hwdata[7:0];
                IDX_HOLD_MM:  hold_mm_q  <= hwdata[7:0];
                IDX_OWN:      own_q      <= hwdata[7:0];
                IDX_CTRL:     ctrl_q     <= {1'b0, hwdata[6:0]};
                IDX_TXD:      txd_q      <= hwdata[7:0];
                IDX_MASK:     mask_q     <= hwdata[EV_W-1:0];
                default:      ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else if (wr_q && idx_q == IDX_STAT) begin
            st_q <= (st_q & ~hwdata[EV_W-1:0]) | ev_q;
        end else begin
            st_q <= st_q | ev_q;
        end
    end

    assign irq = |(st_q & mask_q);

    always_comb begin
        hrdata = 32'h0;
        if (rd_q) begin
            case (idx_q)
                IDX_HOLD_DDC: hrdata[7:0] = hold_ddc_q;
                IDX_HOLD_MM:  hrdata[7:0] = hold_mm_q;
                IDX_DAT:      hrdata[7:0] = dat_q;
                IDX_OWN:      hrdata[7:0] = own_q;
                IDX_BUF:      hrdata[7:0] = mif.rd;
                IDX_TXD:      hrdata[7:0] = txd_q;
                IDX_PTR:      hrdata[AW-1:0] = ptr_q;
                IDX_CTRL:     hrdata[7:0] = {mode2_q, ctrl_q[6:0]};
                IDX_STAT:     hrdata[EV_W-1:0] = st_q;
                IDX_MASK:     hrdata[EV_W-1:0] = mask_q;
                default:      hrdata = 32'h0;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_addr_match;
        (i2c_act && !start_q && !stop_q && !scl_rise && scl_fall && state_q == I2CSD_ADDR
         && bit_q == BIT_LAST && rx_q[7:1] == own_q[7:1]) |=> state_q == I2CSD_AACK ##0 sda_oe;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("Own address not acknowledged.");

    property p_hold_rst;
        $rose(hresetn) |-> (hold_ddc_q == 8'h00) && (hold_mm_q == 8'h00);
    endproperty
    a_hold_rst: assert property (p_hold_rst) else $error("Hold registers not cleared.");

    property p_one_sample;
        (!hold_ddc_q[7] && tick_q && scl_s && sda_s != ref_q) |=> ref_q == $past(sda_s);
    endproperty
    a_one_sample: assert property (p_one_sample) else $error("Bit 7 clear must need one sample.");

    property p_count;
        (start_q || stop_q) |-> $past(cnt_q) + 8'h01 == hold_samples($past(hold_ddc_q));
    endproperty
    a_count: assert property (p_count) else $error("Start or stop before full sample count.");

    property p_tick;
        tick_q |=> !tick_q ##1 tick_q;
    endproperty
    a_tick: assert property (p_tick) else $error("Sample tick not at half rate.");

    property p_stable;
        start_q |-> $past(scl_s) && !$past(sda_s) && !ref_q;
    endproperty
    a_stable: assert property (p_stable) else $error("Start without stable low data.");

    property p_msb;
        (i2c_act && state_q == I2CSD_TX && txv_q) |-> sda_oe == !tx_q[7];
    endproperty
    a_msb: assert property (p_msb) else $error("Transmit bit is not the top bit.");

    property p_ptr;
        (fetch_go && !wr_q && !ptr_set_q) |=> ptr_q == $past(ptr_q) + AW'(1);
    endproperty
    a_ptr: assert property (p_ptr) else $error("Pointer did not step after fetch.");

    property p_fetch;
        (load_next && !sw && !fack_q) |=> fetch_q ##1 1'b1 [*1] ##[0:8] txv_q;
    endproperty
    a_fetch: assert property (p_fetch) else $error("Automatic byte not fetched.");

    property p_swreq;
        (load_next && sw) |=> ev_q[EV_TXREQ] && txv_q;
    endproperty
    a_swreq: assert property (p_swreq) else $error("Software mode did not request a byte.");

    property p_slave_only;
        (i2c_act && sda_oe) |-> state_q inside {I2CSD_AACK, I2CSD_RACK, I2CSD_TX};
    endproperty
    a_slave_only: assert property (p_slave_only) else $error("Data driven outside slave phases.");

    c_addr:   cover property (ev_q[EV_ADDR]);
    c_switch: cover property (ev_q[EV_SWITCH]);
    c_stop:   cover property (ev_q[EV_STOP] ##1 irq);

endmodule // i2csd_top

// File: i2csd_host.sv
`timescale 1ns/1ns
module i2csd_host (
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda,
    output logic      vsync
);
    // ******************************************
    // Open-drain display host with pull-up.
    // ******************************************
    logic sda_m;
    int   t_hold = 120;
    assign sda = sda_oe ? 1'b0 : sda_m;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
        vsync = 1'b0;
    end
    task automatic start();
        sda_m = 1'b1;
        #20 scl = 1'b1;
        #40 sda_m = 1'b0;
        #(t_hold) scl = 1'b0;
        #20;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        #20 scl = 1'b1;
        #40 sda_m = 1'b1;
        #(t_hold);
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_m = b;
        #20 scl = 1'b1;
        #20 r = sda;
        #20 scl = 1'b0;
        #20;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic vtick(output logic r);
        vsync = 1'b1;
        #40 r = sda;
        vsync = 1'b0;
        #40;
    endtask
    task automatic vbyte(output logic [7:0] d);
        logic r;
        vtick(r);
        for (int i = 7; i >= 0; i--) begin
            vtick(r);
            d[i] = r;
        end
    endtask
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(~more, r);
    endtask
endmodule // i2csd_host

// File: i2csd_top_tb.sv
`timescale 1ns/1ns
module i2csd_top_tb;
    import i2csd_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, hr_q, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        scl, sda, vsync, sda_o, sda_oe, ack;
    logic [7:0]  d;
    int          bad_count = 0, n_tests = 0, cyc = 0;
    i2csd_top #(.AW(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .vsync_i(vsync),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    i2csd_host host_u (.sda_oe(sda_oe), .scl(scl), .sda(sda), .vsync(vsync));
    // ******************************************
    // Clock, bus tasks and checks.
    // ******************************************
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) hr_q <= hrdata;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] i, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h000000, i, 2'h0};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        #1 rd = hr_q;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        ahb(1'b1, i, {24'h000000, v}, r);
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        ahb(1'b0, i, 32'h00000000, r);
        chk(r, {24'h000000, e});
    endtask
    task automatic t_regs();
        rdc(IDX_HOLD_DDC, HOLD_RST);
        rdc(IDX_HOLD_MM, HOLD_RST);
        rdc(IDX_OWN, OWN_RST);
        wr(IDX_HOLD_MM, 8'hFF);
        rdc(IDX_HOLD_MM, 8'hFF);
        rdc(8'hE0, 8'h00);
        wr(IDX_PTR, 8'h00);
        for (int i = 0; i < 4; i++) wr(IDX_BUF, 8'h96 + i[7:0]);
        rdc(IDX_PTR, 8'h04);
        wr(IDX_PTR, 8'h00);
        for (int i = 0; i < 4; i++) rdc(IDX_BUF, 8'h96 + i[7:0]);
    endtask
    task automatic t_link();
        wr(IDX_MASK, 8'h01 << EV_ADDR);
        wr(IDX_CTRL, 8'h01);
        host_u.start();
        host_u.wbyte(OWN_RST, ack);
        chk(ack, 1);
        host_u.wbyte(8'h01, ack);
        host_u.start();
        host_u.wbyte(OWN_RST | 8'h01, ack);
        chk(ack, 1);
        host_u.rbyte(1'b1, d);
        chk(d, 8'h97);
        host_u.rbyte(1'b0, d);
        chk(d, 8'h98);
        host_u.stop();
        host_u.start();
        host_u.wbyte(OWN_RST, ack);
        chk(ack, 1);
        host_u.stop();
        rdc(IDX_PTR, 8'h03);
        chk(irq, 1);
        wr(IDX_STAT, 8'h01 << EV_ADDR);
        chk(irq, 0);
        ahb(1'b0, IDX_STAT, 32'h00000000, r);
        chk(r[EV_STOP], 1);
        host_u.start();
        host_u.wbyte(8'h42, ack);
        chk(ack, 0);
        host_u.stop();
    endtask
    task automatic t_hold();
        wr(IDX_HOLD_DDC, 8'h8B);
        host_u.t_hold = 60;
        host_u.start();
        host_u.wbyte(OWN_RST, ack);
        chk(ack, 0);
        host_u.t_hold = 120;
        host_u.stop();
        host_u.start();
        host_u.wbyte(OWN_RST, ack);
        chk(ack, 1);
        host_u.stop();
        wr(IDX_HOLD_DDC, 8'h7F);
        host_u.t_hold = 20;
        host_u.start();
        host_u.wbyte(OWN_RST, ack);
        chk(ack, 1);
        host_u.stop();
    endtask
    task automatic t_ddc1();
        wr(IDX_CTRL, 8'h03);
        host_u.vbyte(d);
        chk(d, 8'h99);
        wr(IDX_TXD, 8'h5A);
        wr(IDX_CTRL, 8'h07);
        host_u.vbyte(d);
        chk(d, 8'h5A);
        ahb(1'b0, IDX_STAT, 32'h00000000, r);
        chk(r[EV_TXREQ], 1);
        rdc(IDX_PTR, 8'h04);
        host_u.start();
        rdc(IDX_CTRL, 8'h87);
        ahb(1'b0, IDX_STAT, 32'h00000000, r);
        chk(r[EV_SWITCH], 1);
        host_u.stop();
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h00000000;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_link();
        t_hold();
        t_ddc1();
        close_out();
    end
endmodule // i2csd_top_tb
